// File: amc_codec.sv
/*
 * authentication message codec top: builds an outgoing message as an
 * octet stream from a request struct, and parses incoming octet streams.
 * assumes sink and source on the same clock; tx stream is valid/ready.
 */
// Behaviour
// - request type 0x40, reply type 0x41
// - message type top bit always zero
// - portable request: auth-type plus portable challenge
// - fixed request: auth-type, seed, fixed challenge
// - reply elements chosen by originator side
// - portable request response only in key allocation
// - reply challenge only gen2 with type-2
// - seed 128 bits gen2 type-2, else 64; receive side expects 128 whenever rx_gen2
// - gen1 values sent most significant first
// - gen2 top bit in octet 3
// - gen2 bottom bits octets 10, 6, 18
// - identifiers 0x0C, 0x0D, 0x0E, 0x0A
// - lengths 10, 6, 5; seed 10 or 18
// - auth-type in every request
`timescale 1ns/1ns
module amc_codec
	import amc_pkg::*;
(
	input  wire logic               clk,
	input  wire logic               resetn,
	input  wire logic               tx_start,
	input  amc_msg_t                tx_msg,
	output logic                    tx_busy,
	output logic                    tx_valid,
	output logic [7:0]              tx_data,
	output logic                    tx_last,
	input  wire logic               tx_ready,
	input  wire logic               rx_gen2,
	input  wire logic               rx_valid,
	input  wire logic [7:0]         rx_data,
	input  wire logic               rx_last,
	output logic                    rx_done,
	output amc_rx_stat_t            rx_stat,
	output amc_msg_t                rx_msg
);

	typedef enum logic [1:0] {
		AMC_T_IDLE = 2'b00,
		AMC_T_TYPE = 2'b01,
		AMC_T_HDR  = 2'b10,
		AMC_T_BODY = 2'b11
	} amc_tst_t;

	amc_tst_t    st_q, st_d;
	amc_msg_t    m_q, m_d;
	logic [3:0]  incl_q, incl_d;
	amc_elem_t   el_q, el_d;
	logic        hdr_q, hdr_d;
	logic [7:0]  left_q, left_d;
	logic [7:0]  out_q, out_d;
	logic        last_q, last_d;
	logic [3:0]  incl;
	logic        wide;
	logic [7:0]  el_id;
	logic [7:0]  el_len;
	logic [3:0]  rest;
	amc_elem_t   next_el;
	logic        any_next;

	assign tx_busy  = (st_q != AMC_T_IDLE);
	assign tx_valid = (st_q != AMC_T_IDLE);
	assign tx_data  = out_q;
	assign tx_last  = last_q;

	// -------------------------------------------------------------------
	// element selection, bit i = amc_elem_t value i
	// -------------------------------------------------------------------
	always_comb begin
		incl = 4'h0;
		wide = tx_msg.gen2 && tx_msg.type2;
		if (!tx_msg.is_reply) begin
			incl[AMC_E_AUTH] = 1'b1;
			incl[AMC_E_CHAL] = 1'b1;
			incl[AMC_E_SEED] = tx_msg.from_fixed;
			incl[AMC_E_RESP] = !tx_msg.from_fixed && tx_msg.key_alloc;
		end else begin
			incl[AMC_E_RESP] = 1'b1;
			incl[AMC_E_SEED] = tx_msg.from_fixed;
			incl[AMC_E_CHAL] = wide;
		end
	end

	// -------------------------------------------------------------------
	// identifier and length of current element
	// -------------------------------------------------------------------
	always_comb begin
		case (el_q)
			AMC_E_AUTH: begin
				el_id  = AMC_EI_AUTH_TYPE;
				el_len = AMC_LEN_AUTH_TYPE;
			end
			AMC_E_SEED: begin
				el_id  = AMC_EI_SEED;
				el_len = (m_q.gen2 && m_q.type2) ? AMC_LEN_SEED_G2 : AMC_LEN_SEED_G1;
			end
			AMC_E_CHAL: begin
				el_id  = AMC_EI_CHALLENGE;
				el_len = AMC_LEN_CHALLENGE;
			end
			AMC_E_RESP: begin
				el_id  = AMC_EI_RESPONSE;
				el_len = AMC_LEN_RESPONSE;
			end
			default: begin
				el_id  = AMC_EI_AUTH_TYPE;
				el_len = AMC_LEN_AUTH_TYPE;
			end
		endcase
	end

	// -------------------------------------------------------------------
	// lowest pending element after removing current
	// -------------------------------------------------------------------
	always_comb begin
		rest     = incl_q & ~(4'h1 << el_q);
		any_next = |rest;
		next_el  = AMC_E_AUTH;
		for (int i = 3; i >= 0; i--) begin
			if (rest[i]) begin
				next_el = amc_elem_t'(i[1:0]);
			end
		end
	end

	// -------------------------------------------------------------------
	// transmit walker
	// -------------------------------------------------------------------
	always_comb begin
		st_d   = st_q;
		m_d    = m_q;
		incl_d = incl_q;
		el_d   = el_q;
		hdr_d  = hdr_q;
		left_d = left_q;
		out_d  = out_q;
		last_d = last_q;
		case (st_q)
			AMC_T_IDLE: begin
				if (tx_start) begin
					m_d    = tx_msg;
					incl_d = incl;
					el_d   = AMC_E_AUTH;
					for (int i = 3; i >= 0; i--) begin
						if (incl[i]) begin
							el_d = amc_elem_t'(i[1:0]);
						end
					end
					out_d  = tx_msg.is_reply ? AMC_MT_REPLY : AMC_MT_REQUEST;
					last_d = 1'b0;
					st_d   = AMC_T_TYPE;
				end
			end
			AMC_T_TYPE: begin
				if (tx_ready) begin
					out_d = el_id;
					hdr_d = 1'b1;
					st_d  = AMC_T_HDR;
				end
			end
			AMC_T_HDR: begin
				if (tx_ready) begin
					if (hdr_q) begin
						out_d  = el_len - AMC_HDR_OCTETS;
						hdr_d  = 1'b0;
					end else begin
						left_d = el_len - AMC_HDR_OCTETS;
						st_d   = AMC_T_BODY;
						// values leave most significant octet first
						case (el_q)
							AMC_E_AUTH: begin
								out_d = m_q.auth_type[AMC_AUTH_TYPE_BITS-1 -: 8];
								m_d.auth_type = m_q.auth_type << 8;
							end
							AMC_E_SEED: begin
								if (m_q.gen2 && m_q.type2) begin
									out_d = m_q.seed[AMC_SEED_BITS-1 -: 8];
									m_d.seed = m_q.seed << 8;
								end else begin
									out_d = m_q.seed[AMC_CHAL_BITS-1 -: 8];
									m_d.seed = {m_q.seed[AMC_SEED_BITS-1:AMC_CHAL_BITS],
										m_q.seed[AMC_CHAL_BITS-9:0], 8'h00};
								end
							end
							AMC_E_CHAL: begin
								out_d = m_q.challenge[AMC_CHAL_BITS-1 -: 8];
								m_d.challenge = m_q.challenge << 8;
							end
							default: begin
								out_d = m_q.response[AMC_RESP_BITS-1 -: 8];
								m_d.response = m_q.response << 8;
							end
						endcase
						last_d = !any_next && (el_len - AMC_HDR_OCTETS == 8'h01);
					end
				end
			end
			AMC_T_BODY: begin
				if (tx_ready) begin
					if (last_q) begin
						st_d   = AMC_T_IDLE;
						last_d = 1'b0;
					end else if (left_q == 8'h01) begin
						incl_d = rest;    // finished element dropped, order only advances
						el_d  = next_el;
						hdr_d = 1'b1;
						st_d  = AMC_T_HDR;
						case (next_el)
							AMC_E_AUTH: out_d = AMC_EI_AUTH_TYPE;
							AMC_E_SEED: out_d = AMC_EI_SEED;
							AMC_E_CHAL: out_d = AMC_EI_CHALLENGE;
							default:    out_d = AMC_EI_RESPONSE;
						endcase
					end else begin
						left_d = left_q - 8'h01;
						last_d = !any_next && (left_q == 8'h02);
						case (el_q)
							AMC_E_AUTH: begin
								out_d = m_q.auth_type[AMC_AUTH_TYPE_BITS-1 -: 8];
								m_d.auth_type = m_q.auth_type << 8;
							end
							AMC_E_SEED: begin
								if (m_q.gen2 && m_q.type2) begin
									out_d = m_q.seed[AMC_SEED_BITS-1 -: 8];
									m_d.seed = m_q.seed << 8;
								end else begin
									out_d = m_q.seed[AMC_CHAL_BITS-1 -: 8];
									m_d.seed = {m_q.seed[AMC_SEED_BITS-1:AMC_CHAL_BITS],
										m_q.seed[AMC_CHAL_BITS-9:0], 8'h00};
								end
							end
							AMC_E_CHAL: begin
								out_d = m_q.challenge[AMC_CHAL_BITS-1 -: 8];
								m_d.challenge = m_q.challenge << 8;
							end
							default: begin
								out_d = m_q.response[AMC_RESP_BITS-1 -: 8];
								m_d.response = m_q.response << 8;
							end
						endcase
					end
				end
			end
			default: st_d = AMC_T_IDLE;
		endcase
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			st_q   <= AMC_T_IDLE;
			m_q    <= '0;
			incl_q <= 4'h0;
			el_q   <= AMC_E_AUTH;
			hdr_q  <= 1'b0;
			left_q <= 8'h00;
			out_q  <= 8'h00;
			last_q <= 1'b0;
		end else begin
			st_q   <= st_d;
			m_q    <= m_d;
			incl_q <= incl_d;
			el_q   <= el_d;
			hdr_q  <= hdr_d;
			left_q <= left_d;
			out_q  <= out_d;
			last_q <= last_d;
		end
	end

	// -------------------------------------------------------------------
	// receive side
	// -------------------------------------------------------------------
	amc_parser u_parser (
		.clk      (clk),
		.resetn   (resetn),
		.gen2     (rx_gen2),
		.rx_valid (rx_valid),
		.rx_data  (rx_data),
		.rx_last  (rx_last),
		.done     (rx_done),
		.stat     (rx_stat),
		.msg      (rx_msg)
	);

endmodule

// File: amc_pkg.sv
/*
 * package for the authentication message codec: message type codes,
 * element identifiers, element lengths, value widths and carrier structs.
 * assumes a single clock domain; no software registers.
 */
package amc_pkg;

	// -------------------------------------------------------------------
	// message types
	// -------------------------------------------------------------------
	localparam logic [7:0] AMC_MT_REQUEST = 8'h40;
	localparam logic [7:0] AMC_MT_REPLY   = 8'h41;
	localparam int         AMC_MT_TOP_BIT = 7;

	// -------------------------------------------------------------------
	// element identifiers and lengths (bytes, whole element)
	// -------------------------------------------------------------------
	localparam logic [7:0] AMC_EI_CHALLENGE = 8'h0C;
	localparam logic [7:0] AMC_EI_RESPONSE  = 8'h0D;
	localparam logic [7:0] AMC_EI_SEED      = 8'h0E;
	localparam logic [7:0] AMC_EI_AUTH_TYPE = 8'h0A;

	localparam logic [7:0] AMC_LEN_CHALLENGE = 8'h0A;
	localparam logic [7:0] AMC_LEN_RESPONSE  = 8'h06;
	localparam logic [7:0] AMC_LEN_SEED_G1   = 8'h0A;
	localparam logic [7:0] AMC_LEN_SEED_G2   = 8'h12;
	localparam logic [7:0] AMC_LEN_AUTH_TYPE = 8'h05;
	localparam logic [7:0] AMC_HDR_OCTETS    = 8'h02;

	// auth-type payload octets carried opaquely
	localparam int AMC_AUTH_TYPE_BITS = 24;
	localparam int AMC_CHAL_BITS      = 64;
	localparam int AMC_RESP_BITS      = 32;
	localparam int AMC_SEED_BITS      = 128;

	// -------------------------------------------------------------------
	// carriers
	// -------------------------------------------------------------------
	typedef enum logic [1:0] {
		AMC_E_AUTH = 2'b00,
		AMC_E_SEED = 2'b01,
		AMC_E_CHAL = 2'b10,
		AMC_E_RESP = 2'b11
	} amc_elem_t;

	typedef struct packed {
		logic                          is_reply;
		logic                          from_fixed;
		logic                          gen2;
		logic                          type2;
		logic                          key_alloc;
		logic [AMC_AUTH_TYPE_BITS-1:0] auth_type;
		logic [AMC_CHAL_BITS-1:0]      challenge;
		logic [AMC_RESP_BITS-1:0]      response;
		logic [AMC_SEED_BITS-1:0]      seed;
	} amc_msg_t;

	typedef struct packed {
		logic       is_auth;
		logic       is_reply;
		logic       has_auth_type;
		logic       has_seed;
		logic       has_challenge;
		logic       has_response;
		logic       err;
	} amc_rx_stat_t;

endpackage

// File: amc_parser.sv
/*
 * receive-side parser: walks an octet stream of one message, checks type,
 * identifiers and lengths, and extracts values most significant first.
 * assumes octets from logic on the same clock; rx_last marks final octet.
 */
`timescale 1ns/1ns
module amc_parser
	import amc_pkg::*;
(
	input  wire logic               clk,
	input  wire logic               resetn,
	input  wire logic               gen2,
	input  wire logic               rx_valid,
	input  wire logic [7:0]         rx_data,
	input  wire logic               rx_last,
	output logic                    done,
	output amc_rx_stat_t            stat,
	output amc_msg_t                msg
);

	typedef enum logic [1:0] {
		AMC_P_TYPE = 2'b00,
		AMC_P_EI   = 2'b01,
		AMC_P_LEN  = 2'b10,
		AMC_P_BODY = 2'b11
	} amc_pst_t;

	amc_pst_t     st_q, st_d;
	logic [7:0]   ei_q, ei_d;
	logic [7:0]   left_q, left_d;
	logic         done_q, done_d;
	amc_rx_stat_t stat_q, stat_d;
	amc_msg_t     msg_q, msg_d;
	logic [7:0]   exp_len;
	logic         known;

	assign done = done_q;
	assign stat = stat_q;
	assign msg  = msg_q;

	// -------------------------------------------------------------------
	// expected length per identifier
	// -------------------------------------------------------------------
	always_comb begin
		known   = 1'b1;
		exp_len = AMC_LEN_CHALLENGE;
		case (ei_q)
			AMC_EI_CHALLENGE: exp_len = AMC_LEN_CHALLENGE;
			AMC_EI_RESPONSE:  exp_len = AMC_LEN_RESPONSE;
			AMC_EI_SEED:      exp_len = gen2 ? AMC_LEN_SEED_G2 : AMC_LEN_SEED_G1;
			AMC_EI_AUTH_TYPE: exp_len = AMC_LEN_AUTH_TYPE;
			default:          known   = 1'b0;
		endcase
	end

	// -------------------------------------------------------------------
	// walker
	// -------------------------------------------------------------------
	always_comb begin
		st_d   = st_q;
		ei_d   = ei_q;
		left_d = left_q;
		done_d = 1'b0;
		stat_d = stat_q;
		msg_d  = msg_q;
		msg_d.gen2 = gen2;
		if (rx_valid) begin
			case (st_q)
				AMC_P_TYPE: begin
					stat_d = '0;
					stat_d.is_auth = ~rx_data[AMC_MT_TOP_BIT] &&
						(rx_data == AMC_MT_REQUEST || rx_data == AMC_MT_REPLY);
					stat_d.is_reply = (rx_data == AMC_MT_REPLY);
					msg_d.is_reply  = (rx_data == AMC_MT_REPLY);
					st_d = AMC_P_EI;
				end
				AMC_P_EI: begin
					ei_d = rx_data;
					st_d = AMC_P_LEN;
				end
				AMC_P_LEN: begin
					// length octet counts contents; element = contents + header
					if (!known || (rx_data + AMC_HDR_OCTETS) != exp_len) begin
						stat_d.err = 1'b1;
					end
					left_d = rx_data;
					st_d   = (rx_data == 8'h00) ? AMC_P_EI : AMC_P_BODY;
				end
				AMC_P_BODY: begin
					case (ei_q)
						AMC_EI_CHALLENGE: begin
							msg_d.challenge = {msg_q.challenge[AMC_CHAL_BITS-9:0], rx_data};
							stat_d.has_challenge = 1'b1;
						end
						AMC_EI_RESPONSE: begin
							msg_d.response = {msg_q.response[AMC_RESP_BITS-9:0], rx_data};
							stat_d.has_response = 1'b1;
						end
						AMC_EI_SEED: begin
							msg_d.seed = {msg_q.seed[AMC_SEED_BITS-9:0], rx_data};
							stat_d.has_seed = 1'b1;
						end
						AMC_EI_AUTH_TYPE: begin
							msg_d.auth_type = {msg_q.auth_type[AMC_AUTH_TYPE_BITS-9:0], rx_data};
							stat_d.has_auth_type = 1'b1;
						end
						default: begin
						end
					endcase
					left_d = left_q - 8'h01;
					if (left_q == 8'h01) begin
						st_d = AMC_P_EI;
					end
				end
				default: st_d = AMC_P_TYPE;
			endcase
			if (rx_last) begin
				if (st_q != AMC_P_TYPE && !(st_q == AMC_P_BODY && left_q == 8'h01) &&
				    !(st_q == AMC_P_LEN && rx_data == 8'h00)) begin
					stat_d.err = 1'b1;
				end
				if (!stat_d.is_reply && !stat_d.has_auth_type) begin
					stat_d.err = 1'b1;
				end
				st_d   = AMC_P_TYPE;
				done_d = 1'b1;
			end
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			st_q   <= AMC_P_TYPE;
			ei_q   <= 8'h00;
			left_q <= 8'h00;
			done_q <= 1'b0;
			stat_q <= '0;
			msg_q  <= '0;
		end else begin
			st_q   <= st_d;
			ei_q   <= ei_d;
			left_q <= left_d;
			done_q <= done_d;
			stat_q <= stat_d;
			msg_q  <= msg_d;
		end
	end

endmodule

// File: amc_codec_monitor.sv
/*
 * checker for amc_codec: type octet of built messages, first two element headers of requests,
 * stall holding, end of message and receive completion.
 * assumes it sees only the codec's ports; bound below.
 */
`timescale 1ns/1ns
module amc_codec_monitor
	import amc_pkg::*;
(
	input  wire logic   clk,
	input  wire logic   resetn,
	input  wire logic   tx_start,
	input  amc_msg_t    tx_msg,
	input  wire logic   tx_busy,
	input  wire logic   tx_valid,
	input  wire logic [7:0] tx_data,
	input  wire logic   tx_last,
	input  wire logic   tx_ready,
	input  wire logic   rx_gen2,
	input  wire logic   rx_valid,
	input  wire logic [7:0] rx_data,
	input  wire logic   rx_last,
	input  wire logic   rx_done,
	input  amc_rx_stat_t rx_stat,
	input  amc_msg_t    rx_msg
);
	// ---------------------------------------------------------------
	// octet index and captured flags
	// ---------------------------------------------------------------
	logic [5:0] oct_q, oct_d;
	logic [2:0] cap_q, cap_d;
	logic       first_q, first_d;
	logic       bad_q, bad_d;

	always_comb begin
		oct_d   = oct_q;
		cap_d   = cap_q;
		first_d = first_q;
		bad_d   = bad_q;
		if (tx_start && !tx_busy) begin
			oct_d = 6'h00;
			cap_d = {!tx_msg.is_reply, tx_msg.from_fixed, tx_msg.gen2 & tx_msg.type2};
		end else if (tx_valid && tx_ready) begin
			oct_d = oct_q + 6'h01;
		end
		if (rx_valid && first_q)
			bad_d = !(rx_data inside {8'h40, 8'h41});
		if (rx_valid)
			first_d = rx_last;
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			oct_q   <= 6'h00;
			cap_q   <= 3'h0;
			first_q <= 1'b1;
			bad_q   <= 1'b0;
		end else begin
			oct_q   <= oct_d;
			cap_q   <= cap_d;
			first_q <= first_d;
			bad_q   <= bad_d;
		end
	end

	// ---------------------------------------------------------------
	// properties
	// ---------------------------------------------------------------
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);

	sequence s_start;
		tx_start && !tx_busy;
	endsequence
	sequence s_acc_last;
		tx_valid && tx_ready && tx_last;
	endsequence
	sequence s_rx_end;
		rx_valid && rx_last;
	endsequence

	AST_TX_TYPE:
		assert property (s_start |=> tx_valid && tx_data == {7'h20, $past(tx_msg.is_reply)})
		else $error("wrong message type octet");
	AST_TX_HOLD:
		assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data) && $stable(tx_last))
		else $error("octet changed while stalled");
	AST_TX_END:
		assert property (s_acc_last |=> !tx_valid)
		else $error("octet offered after last");
	AST_AUTH_ID:
		assert property (tx_valid && cap_q[2] && oct_q == 6'h01 |-> tx_data == 8'h0A)
		else $error("request lacks auth-type first");
	AST_AUTH_LEN:
		assert property (tx_valid && cap_q[2] && oct_q == 6'h02 |-> tx_data == 8'h03)
		else $error("auth-type length wrong");
	AST_SECOND_ID:
		assert property (tx_valid && cap_q[2] && oct_q == 6'h06
			|-> tx_data == (cap_q[1] ? 8'h0E : 8'h0C))
		else $error("second request element wrong");
	AST_SECOND_LEN:
		assert property (tx_valid && cap_q[2] && oct_q == 6'h07
			|-> tx_data == (cap_q[1] && cap_q[0] ? 8'h10 : 8'h08))
		else $error("second request element length wrong");
	AST_RX_DONE:
		assert property (s_rx_end |=> rx_done)
		else $error("no done after last octet");
	AST_DONE_CAUSE:
		assert property (rx_done |-> $past(rx_valid && rx_last))
		else $error("done without last octet");
	AST_RX_TYPE:
		assert property (rx_done |-> rx_stat.is_auth == !bad_q)
		else $error("message type not judged right");
endmodule

bind amc_codec amc_codec_monitor mon (
	.clk(clk), .resetn(resetn), .tx_start(tx_start), .tx_msg(tx_msg),
	.tx_busy(tx_busy), .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last),
	.tx_ready(tx_ready), .rx_gen2(rx_gen2), .rx_valid(rx_valid), .rx_data(rx_data),
	.rx_last(rx_last), .rx_done(rx_done), .rx_stat(rx_stat), .rx_msg(rx_msg)
);

// File: amc_peer.sv
/*
 * peer terminal model: collects built octets, stalls on request,
 * and sends octet streams into the codec's receive side.
 * assumes the codec's clock; driven just after rising edges.
 */
`timescale 1ns/1ns
module amc_peer (
	input  wire logic       clk,
	input  wire logic       tx_valid,
	input  wire logic [7:0] tx_data,
	output logic            tx_ready,
	output logic            rx_valid,
	output logic [7:0]      rx_data,
	output logic            rx_last
);
	logic [7:0] got[$];
	bit         slow = 1'b0;

	initial begin
		tx_ready = 1'b1;
		rx_valid = 1'b0;
		rx_data  = 8'hA5;
		rx_last  = 1'b0;
	end

	// accept, then toggle ready when slow
	always @(posedge clk) begin
		if (tx_valid && tx_ready)
			got.push_back(tx_data);
		#1 tx_ready = slow ? ~tx_ready : 1'b1;
	end

	// one octet per cycle, most significant first as queued
	task automatic send(input logic [7:0] b[$]);
		for (int i = 0; i < b.size(); i++) begin
			rx_valid = 1'b1;
			rx_data  = b[i];
			rx_last  = (i == b.size() - 1);
			@(posedge clk);
			#1;
		end
		rx_valid = 1'b0;
		rx_last  = 1'b0;
		rx_data  = ~rx_data;
	endtask
endmodule

// File: testbench.sv
/*
 * testbench for amc_codec: builds messages of every originator and
 * procedure, parses good and faulty streams.
 * assumes amc_peer as far side and the bound checker.
 */
`timescale 1ns/1ns
module testbench
	import amc_pkg::*;
;
	logic         clk = 1'b0;
	logic         resetn = 1'b0;
	logic         tx_start = 1'b0;
	logic         rx_gen2 = 1'b0;
	amc_msg_t     tx_msg = '0;
	logic         tx_busy, tx_valid, tx_last, tx_ready;
	logic         rx_valid, rx_last, rx_done;
	logic [7:0]   tx_data, rx_data;
	amc_rx_stat_t rx_stat;
	amc_msg_t     rx_msg;
	int           mismatches = 0;
	int           total_checks = 0;
	logic [7:0]   exp_q[$];

	always #5 clk = ~clk;

	amc_codec uut (.clk(clk), .resetn(resetn), .tx_start(tx_start), .tx_msg(tx_msg),
		.tx_busy(tx_busy), .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last),
		.tx_ready(tx_ready), .rx_gen2(rx_gen2), .rx_valid(rx_valid), .rx_data(rx_data),
		.rx_last(rx_last), .rx_done(rx_done), .rx_stat(rx_stat), .rx_msg(rx_msg));
	amc_peer peer (.clk(clk), .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready),
		.rx_valid(rx_valid), .rx_data(rx_data), .rx_last(rx_last));

	// ---------------------------------------------------------------
	// compares and builders
	// ---------------------------------------------------------------
	task automatic chk_b(input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("Error %0t: octet %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chk_v(input logic [127:0] got, input logic [127:0] exp);
		total_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("Error %0t: value %h expected %h", $time, got, exp);
		end
	endtask
	task automatic put(input logic [7:0] id, input int n, input logic [127:0] v);
		exp_q.push_back(id);
		exp_q.push_back(n[7:0]);
		for (int i = n - 1; i >= 0; i--)
			exp_q.push_back(v[8*i +: 8]);
	endtask
	function automatic amc_msg_t mk(input logic [4:0] f);
		return {f, 24'h812C_3D, 64'h8A5C_0FF0_1234_5601, 32'h9BAD_C0D1,
			128'h8123_4567_89AB_CDEF_FEDC_BA98_7654_3211};
	endfunction
	task automatic build(input amc_msg_t m);
		logic w;
		w = m.gen2 & m.type2;
		exp_q = {};
		exp_q.push_back({7'h20, m.is_reply});
		if (!m.is_reply) put(8'h0A, 3, m.auth_type);
		if (m.from_fixed) put(8'h0E, w ? 16 : 8, m.seed);
		if (!m.is_reply || w) put(8'h0C, 8, m.challenge);
		if (m.is_reply || (!m.from_fixed && m.key_alloc)) put(8'h0D, 4, m.response);
	endtask
	task automatic run_tx(input amc_msg_t m, input bit slow);
		int n;
		build(m);
		peer.got = {};
		peer.slow = slow;
		tx_msg = m;
		tx_start = 1'b1;
		@(posedge clk);
		#1 tx_start = 1'b0;
		n = 0;
		while (peer.got.size() < exp_q.size() && n < 400) begin
			@(posedge clk);
			#1 n++;
		end
		@(posedge clk);
		#1 chk_b({7'h00, tx_busy}, 8'h00);
		chk_v(peer.got.size(), exp_q.size());
		foreach (exp_q[i]) chk_b(peer.got[i], exp_q[i]);
		peer.slow = 1'b0;
	endtask
	task automatic run_rx(input logic g2);
		rx_gen2 = g2;
		@(posedge clk);
		#1 peer.send(exp_q);
		chk_b({7'h00, rx_done}, 8'h01);
	endtask

	// ---------------------------------------------------------------
	// scenarios
	// ---------------------------------------------------------------
	task automatic t_rx_fixed_g2;
		amc_msg_t m;
		m = mk(5'h0E);
		build(m);
		run_rx(1'b1);
		chk_b({1'b0, rx_stat}, 8'h5C);
		chk_v(rx_msg.seed, m.seed);
		chk_v(rx_msg.challenge, m.challenge);
		chk_v(rx_msg.auth_type, m.auth_type);
	endtask
	task automatic t_rx_reply_g1;
		amc_msg_t m;
		m = mk(5'h18);
		build(m);
		run_rx(1'b0);
		chk_b({1'b0, rx_stat}, 8'h6A);
		chk_v(rx_msg.response, m.response);
		chk_v(rx_msg.seed[63:0], m.seed[63:0]);
	endtask
	task automatic t_rx_bad_len;
		build(mk(5'h08));
		run_rx(1'b1);
		chk_b({7'h00, rx_stat.err}, 8'h01);
	endtask
	task automatic t_rx_unknown;
		build(mk(5'h00));
		exp_q.push_back(8'h0F);
		exp_q.push_back(8'h01);
		exp_q.push_back(8'h3C);
		run_rx(1'b0);
		chk_b({6'h00, rx_stat.err, rx_stat.has_challenge}, 8'h03);
	endtask
	task automatic t_rx_not_auth;
		build(mk(5'h00));
		exp_q[0] = 8'hC0;
		run_rx(1'b0);
		chk_b({7'h00, rx_stat.is_auth}, 8'h00);
	endtask

	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	initial begin
		repeat (16) @(posedge clk);
		#1 resetn = 1'b1;
		@(posedge clk);
		#1 run_tx(mk(5'h00), 1'b0);
		run_tx(mk(5'h01), 1'b1);
		run_tx(mk(5'h0E), 1'b1);
		run_tx(mk(5'h0D), 1'b0);
		run_tx(mk(5'h10), 1'b0);
		run_tx(mk(5'h16), 1'b0);
		run_tx(mk(5'h1E), 1'b1);
		t_rx_fixed_g2();
		t_rx_reply_g1();
		t_rx_bad_len();
		t_rx_unknown();
		t_rx_not_auth();
		tally_and_finish();
	end

	// watchdog: tests need well under 2000 cycles
	initial begin
		#200000;
		mismatches++;
		tally_and_finish();
	end
endmodule
